/* File: core/fws_defs.svh */
`ifndef FWS_DEFS_SVH
`define FWS_DEFS_SVH

// ----------------------------------------------------------------------------
// Register map of the controller (APB, byte addresses).
// ----------------------------------------------------------------------------
`define FWS_REG_CTRL      8'h00
`define FWS_REG_ADDR      8'h04
`define FWS_REG_WDATA     8'h08
`define FWS_REG_STATUS    8'h0c
`define FWS_REG_RDATA     8'h10

// ----------------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------------
`define FWS_CTRL_GO       0
`define FWS_CTRL_OP_LO    1
`define FWS_CTRL_OP_HI    3
`define FWS_ST_BUSY       0
`define FWS_ST_DONE       1
`define FWS_ST_FAIL       2
`define FWS_ST_REJECT     3
`define FWS_ST_RDY        4
`define FWS_ST_SUSP       5

// ----------------------------------------------------------------------------
// Data bus bit positions of the status bits.
// ----------------------------------------------------------------------------
`define FWS_DQ_POLL       7
`define FWS_DQ_TOGGLE     6
`define FWS_DQ_TIMEOUT    5
`define FWS_DQ_WINDOW     3
`define FWS_DQ_SECTOG     2

// ----------------------------------------------------------------------------
// Operation codes written into the control register.
// ----------------------------------------------------------------------------
`define FWS_OP_READ       3'h0
`define FWS_OP_WRITE      3'h1
`define FWS_OP_POLL       3'h2
`define FWS_OP_WINDOW     3'h3
`define FWS_OP_RESET      3'h4

// ----------------------------------------------------------------------------
// Timing: last count of a strobe phase (a phase lasts one clock more) and the reset command word.
// ----------------------------------------------------------------------------
`define FWS_PHASE_CYC     4'h6
`define FWS_RESET_CMD     16'h00f0
`define FWS_WINDOW_US     50
`define FWS_CLK_MHZ       200

`endif

/* File: core/fws_pkg.sv */
package fws_pkg;

  // --------------------------------------------------------------------------
  // Strobes and address toward the flash.
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        ceN;
    logic        oeN;
    logic        weN;
    logic [21:0] addr;
  } fws_pins_type;

  // Sequencer states.
  typedef enum logic [3:0] {
    ST_IDLE, ST_WR_SET, ST_WR_HOLD, ST_RD_SET, ST_RD_HOLD, ST_EVAL, ST_FINISH
  } fws_state_type;

endpackage : fws_pkg

/* File: core/fws_host.sv */
`timescale 1ns/1ps
`include "fws_defs.svh"
// Functional notes
// - Combine both toggle bits for sector and mode.
// - Start polling with two back-to-back reads.
// - Unchanged toggle means done; next read data.
// - Still toggling: check timeout bit, then retest.
// - Toggling after timeout means failure; issue reset.
// - Resumed polling restarts from double read.
// - After timeout, host issues reset command.
// - Window check skippable under 50 us spacing.
// - Check window bit before and after commands.
// - Status reads use a valid sector address.
// - Status reads address the busy bank.
module fws_host (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  output fws_pkg::fws_pins_type     flashPins,
  output logic      [15:0]          dqOut,
  output logic                      dqOe,
  input  wire logic [15:0]          dqIn,
  input  wire logic                 readyBusyN
);
  import fws_pkg::*;

  // --------------------------------------------------------------------------
  // Registers and synchronisers.
  // --------------------------------------------------------------------------
  fws_state_type state_r;            // Sequencer state.
  logic [2:0]    op_r;               // Operation in progress.
  logic [21:0]   addr_r;             // Bank and sector address in use.
  logic [15:0]   wdata_r;            // Word written by a write cycle.
  logic [15:0]   rdata_r;            // Last word read from the flash.
  logic [15:0]   first_r;            // First word of a toggle pair.
  logic          havePair_r;         // A first read is stored.
  logic          sawTimeout_r;       // Timeout bit seen while toggling.
  logic          busy_r;             // Sequence running.
  logic          done_r;             // Sticky: operation finished well.
  logic          fail_r;             // Sticky: operation failed.
  logic          reject_r;           // Sticky: window bit high after command.
  logic          susp_r;             // Sector shows erase-suspend pattern.
  logic [3:0]    phase_r;            // Strobe phase counter.
  logic [15:0]   dqS1_r, dqS2_r, dqS3_r;   // Data bus synchroniser.
  logic [2:0]    rbS_r;              // Ready/busy synchroniser.
  logic [15:0]   dqStable_r;         // Value accepted once stages agree.
  logic          rbStable_r;         // Ready/busy level accepted.

  logic          apbWr;              // Write access completes.
  logic          goCmd;              // Software start request.
  logic          phaseEnd;           // Strobe phase elapsed.
  logic          togglesDiffer;      // Operation toggle changed.

  assign pready  = 1'b1;             // Slave answers in the access cycle.
  assign pslverr = 1'b0;
  assign apbWr   = psel && penable && pwrite;
  assign goCmd   = apbWr && (paddr == `FWS_REG_CTRL) && pwdata[`FWS_CTRL_GO] && !busy_r;
  assign phaseEnd = (phase_r == `FWS_PHASE_CYC);
  // The sector toggle bit alone cannot show the mode, so only the operation
  // toggle decides completion; the sector bit is kept for software.
  assign togglesDiffer = first_r[`FWS_DQ_TOGGLE] ^ dqStable_r[`FWS_DQ_TOGGLE];

  // --------------------------------------------------------------------------
  // Input synchronisers: a change counts when stages two and three agree.
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dqS1_r     <= 16'h0000;
      dqS2_r     <= 16'h0000;
      dqS3_r     <= 16'h0000;
      rbS_r      <= 3'h7;
      dqStable_r <= 16'h0000;
      rbStable_r <= 1'b1;
    end else begin
      dqS1_r <= dqIn;
      dqS2_r <= dqS1_r;
      dqS3_r <= dqS2_r;
      rbS_r  <= {rbS_r[1:0], readyBusyN};
      if (dqS2_r == dqS3_r) begin
        dqStable_r <= dqS3_r;
      end
      if (rbS_r[1] == rbS_r[2]) begin
        rbStable_r <= rbS_r[2];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Software registers: address and data words.
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      addr_r  <= 22'h000000;
      wdata_r <= 16'h0000;
      op_r    <= `FWS_OP_READ;
    end else begin
      if (apbWr && !busy_r && paddr == `FWS_REG_ADDR) begin
        // Status reads must target the busy bank and sector.
        addr_r <= pwdata[21:0];
      end
      if (apbWr && !busy_r && paddr == `FWS_REG_WDATA) begin
        wdata_r <= pwdata[15:0];
      end
      if (goCmd) begin
        op_r <= pwdata[`FWS_CTRL_OP_HI:`FWS_CTRL_OP_LO];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read mux for software.
  // --------------------------------------------------------------------------
  always_comb begin
    prdata = 32'h00000000;
    unique case (paddr)
      `FWS_REG_CTRL:   prdata = {28'h0000000, op_r, busy_r};
      `FWS_REG_ADDR:   prdata = {10'h000, addr_r};
      `FWS_REG_WDATA:  prdata = {16'h0000, wdata_r};
      `FWS_REG_STATUS: prdata = {26'h0000000, susp_r, rbStable_r, reject_r, fail_r, done_r, busy_r};
      `FWS_REG_RDATA:  prdata = {16'h0000, rdata_r};
      default:         prdata = 32'h00000000;
    endcase
  end

  // --------------------------------------------------------------------------
  // Phase counter: each strobe phase lasts a fixed number of clocks.
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst || state_r == ST_IDLE || state_r == ST_EVAL || phaseEnd) begin
      phase_r <= 4'h0;
    end else begin
      phase_r <= phase_r + 4'h1;
    end
  end

  // --------------------------------------------------------------------------
  // Sequencer: write cycles, read cycles and the toggle poll loop.
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r      <= ST_IDLE;
      busy_r       <= 1'b0;
      havePair_r   <= 1'b0;
      sawTimeout_r <= 1'b0;
      first_r      <= 16'h0000;
      rdata_r      <= 16'h0000;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (goCmd) begin
            busy_r <= 1'b1;
            // Each new poll starts from its first double read.
            havePair_r   <= 1'b0;
            sawTimeout_r <= 1'b0;
            if (pwdata[`FWS_CTRL_OP_HI:`FWS_CTRL_OP_LO] == `FWS_OP_WRITE ||
                pwdata[`FWS_CTRL_OP_HI:`FWS_CTRL_OP_LO] == `FWS_OP_RESET) begin
              state_r <= ST_WR_SET;
            end else begin
              state_r <= ST_RD_SET;
            end
          end
        end
        ST_WR_SET:  if (phaseEnd) state_r <= ST_WR_HOLD;
        ST_WR_HOLD: if (phaseEnd) state_r <= ST_FINISH;
        ST_RD_SET:  if (phaseEnd) state_r <= ST_RD_HOLD;
        ST_RD_HOLD: begin
          if (phaseEnd) begin
            rdata_r <= dqStable_r;
            state_r <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          if (op_r != `FWS_OP_POLL) begin
            state_r <= ST_FINISH;
          end else if (!havePair_r) begin
            first_r    <= rdata_r;
            havePair_r <= 1'b1;
            state_r    <= ST_RD_SET;
          end else if (!(first_r[`FWS_DQ_TOGGLE] ^ rdata_r[`FWS_DQ_TOGGLE])) begin
            // No toggle: finished; the next read returns array data.
            state_r <= ST_FINISH;
          end else if (sawTimeout_r) begin
            // Still toggling after the timeout bit: failed.
            state_r <= ST_FINISH;
          end else begin
            // Toggling: note timeout, then retest toggling.
            sawTimeout_r <= rdata_r[`FWS_DQ_TIMEOUT];
            first_r      <= rdata_r;
            state_r      <= ST_RD_SET;
          end
        end
        ST_FINISH: begin
          busy_r  <= 1'b0;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Sticky result flags; a new start clears them.
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst || goCmd) begin
      done_r   <= 1'b0;
      fail_r   <= 1'b0;
      reject_r <= 1'b0;
      susp_r   <= 1'b0;
    end else if (state_r == ST_EVAL) begin
      if (op_r == `FWS_OP_POLL && havePair_r) begin
        if (!(first_r[`FWS_DQ_TOGGLE] ^ rdata_r[`FWS_DQ_TOGGLE])) begin
          done_r <= 1'b1;
          // Sector toggling while operation toggle stands: suspended.
          susp_r <= first_r[`FWS_DQ_SECTOG] ^ rdata_r[`FWS_DQ_SECTOG];
        end else if (sawTimeout_r) begin
          fail_r <= 1'b1;
        end
      end
      if (op_r == `FWS_OP_WINDOW) begin
        // A high window bit after a further erase command flags rejection.
        // The window bit is read only on request, so software may skip it.
        reject_r <= rdata_r[`FWS_DQ_WINDOW];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pin drive. Write and output enables fall only in the hold phase so setup is met.
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flashPins <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, addr: 22'h000000};
      dqOut     <= 16'h0000;
      dqOe      <= 1'b0;
    end else begin
      flashPins.addr <= addr_r;
      flashPins.ceN  <= !(state_r inside {ST_WR_SET, ST_WR_HOLD, ST_RD_SET, ST_RD_HOLD});
      // Write enable rises one clock before chip enable and data are
      // released, so the flash latches a word that still stands.
      flashPins.weN  <= !(state_r == ST_WR_HOLD && !phaseEnd);
      // Reads are strobed by output enable; the chip enable rises with it at the end of each read.
      flashPins.oeN  <= !(state_r == ST_RD_HOLD);
      dqOe           <= (state_r == ST_WR_SET) || (state_r == ST_WR_HOLD);
      dqOut          <= (op_r == `FWS_OP_RESET) ? `FWS_RESET_CMD : wdata_r;
    end
  end

  // --------------------------------------------------------------------------
  // Checks.
  // --------------------------------------------------------------------------
  chk_strobe_excl: assert property (@(posedge ref_clk) disable iff (rst)
    !(!flashPins.weN && !flashPins.oeN)) else $error("write and output enable both low");
  chk_fail_timeout: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(fail_r) |-> $past(sawTimeout_r)) else $error("fail without timeout seen");
  chk_done_pair: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(done_r) |-> $past(havePair_r)) else $error("done before two reads");
  chk_bus_release: assert property (@(posedge ref_clk) disable iff (rst)
    dqOe |-> !flashPins.ceN) else $error("data driven without chip enable");
  chk_read_select: assert property (@(posedge ref_clk) disable iff (rst)
    !flashPins.oeN |-> !flashPins.ceN) else $error("output enable without chip enable");
  chk_write_data: assert property (@(posedge ref_clk) disable iff (rst)
    !flashPins.weN |-> dqOe) else $error("write strobe without data driven");

endmodule : fws_host

/* File: testbench/fws_flash_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Behavioural flash device: program status bits and ready/busy.
// ----------------------------------------------------------------------------
module fws_flash_model #(
  parameter int PROG_READS = 4,  // Busy reads before a good program ends.
  parameter int ERR_READS  = 3   // Busy reads before the pulse limit trips.
) (
  input  wire logic        ceN,
  input  wire logic        oeN,
  input  wire logic        weN,
  input  wire logic [21:0] addr,
  input  wire logic [15:0] dqWr,
  output logic      [15:0] dqRd,
  output logic             readyBusyN
);
  logic [15:0] mem [0:15];  // Tiny array, one word per low address.
  logic        busy;        // Embedded program running.
  logic        tog;         // Operation toggle bit.
  logic        err;         // Timeout error bit.
  logic        bad;         // Program tried to turn a 0 into a 1.
  logic [21:0] pa;          // Program address.
  logic [15:0] pd;          // Program data.
  logic [15:0] last;        // Last word shown, inverted when the bus is free.
  logic [15:0] shown;       // Word the device would drive now.
  int          cnt;         // Busy reads so far.
  wire         rdAct = ~ceN & ~oeN & weN;
  wire         stat  = busy && addr[21:19] == pa[21:19];
  initial begin
    busy = 0;
    tog = 0;
    err = 0;
    bad = 0;
    cnt = 0;
    pa = '0;
    pd = '0;
    last = '0;
    for (int i = 0; i < 16; i++) mem[i] = {4{4'(i)}};
  end
  // A word is taken at the rising write strobe; status is valid from then on.
  always @(posedge weN) begin
    if (ceN === 1'b0) begin
      if (dqWr == 16'h00f0) begin
        busy = 0;
        err = 0;
      end else if (!busy) begin
        busy = 1;
        cnt = 0;
        pa = addr;
        pd = dqWr;
        bad = |(dqWr & ~mem[addr[3:0]]);
      end
    end
  end
  // Each finished read of the busy bank advances the algorithm by one step.
  // A read ends on either output enable or chip enable rising.
  always @(negedge rdAct) begin
    last = shown;
    if (stat) begin
      tog = ~tog;
      cnt++;
      if (bad && cnt >= ERR_READS) err = 1;
      if (!bad && cnt >= PROG_READS) begin
        mem[pa[3:0]] = pd;
        busy = 0;
      end
    end
  end
  // Status replaces bits 7, 6 and 5 only in the busy bank.
  always @* begin
    shown = mem[addr[3:0]];
    if (stat) shown[7:5] = {~pd[7], tog, err};
  end
  // A released bus does not keep the old word, so the reader cannot rely on it.
  assign dqRd = rdAct ? shown : ~last;
  assign readyBusyN = ~busy;
endmodule : fws_flash_model

/* File: testbench/fws_host_tb.sv */
`timescale 1ns/1ps
`include "fws_defs.svh"
// ----------------------------------------------------------------------------
// Bench: APB driver notes expectations, a monitor compares read data.
// ----------------------------------------------------------------------------
module fws_host_tb;
  import fws_pkg::*;
  typedef struct packed { logic [31:0] mask; logic [31:0] exp; } fws_note_type;
  logic         ref_clk = 0;
  logic         rst = 1;
  logic         psel = 0;
  logic         penable = 0;
  logic         pwrite = 0;
  logic         noteRd = 0;      // Marks a read whose data is checked.
  logic [7:0]   paddr = '0;
  logic [31:0]  pwdata = '0;
  logic [31:0]  rdv;             // Data of the last APB read.
  logic [31:0]  seed = 32'h2d14db1a;
  logic [31:0]  prdata;
  logic         pready, pslverr, dqOe, readyBusyN;
  logic [15:0]  dqOut, dqFl, d;
  fws_pins_type flashPins;
  int           error_cnt = 0;
  int           comparisons = 0;
  int           cyc = 0;
  fws_note_type notes[$];
  wire  [15:0]  dqIn = dqOe ? dqOut : dqFl;
  always #2.5 ref_clk = ~ref_clk;
  fws_host u_fws_host (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flashPins(flashPins), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn), .readyBusyN(readyBusyN));
  fws_flash_model u_fws_flash_model (.ceN(flashPins.ceN), .oeN(flashPins.oeN), .weN(flashPins.weN),
    .addr(flashPins.addr), .dqWr(dqIn), .dqRd(dqFl), .readyBusyN(readyBusyN));
  // ----------------------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  // One APB transfer; the request stands until pready is seen at an edge.
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] wd, logic nt);
    @(posedge ref_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    noteRd <= nt;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdv = prdata;
    psel <= 0;
    penable <= 0;
    noteRd <= 0;
  endtask : apb
  task automatic note(logic [7:0] a, logic [31:0] mask, logic [31:0] exp);
    notes.push_back({mask, exp});
    apb(0, a, 0, 1);
  endtask : note
  // Starts one operation and polls the busy flag under a bounded count.
  task automatic run(logic [2:0] op, logic [21:0] a, logic [15:0] wd);
    int k = 0;
    apb(1, `FWS_REG_ADDR, {10'h0, a}, 0);
    apb(1, `FWS_REG_WDATA, {16'h0, wd}, 0);
    apb(1, `FWS_REG_CTRL, {28'h0, op, 1'b1}, 0);
    rdv = 1;
    while (rdv[`FWS_ST_BUSY] !== 1'b0 && k < 2000) begin
      apb(0, `FWS_REG_STATUS, 0, 0);
      k++;
    end
  endtask : run
  // ----------------------------------------------------------------------------
  // Monitor: takes the oldest note at each checked read and the hang limit.
  // ----------------------------------------------------------------------------
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end else if (psel && penable && pready && noteRd && notes.size() > 0) begin
      check("prdata", prdata & notes[0].mask, notes[0].exp);
      void'(notes.pop_front());
    end
  end
  // ----------------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 0;
    run(`FWS_OP_READ, 22'h000001, 0);
    note(`FWS_REG_STATUS, 32'h17, 32'h10);
    note(`FWS_REG_RDATA, 32'hffff, 32'h1111);
    $display("test idle read done");
    rdv = xs();
    d = rdv[15:0] | 16'h8000;
    run(`FWS_OP_WRITE, 22'h00000f, d);
    run(`FWS_OP_POLL, 22'h00000f, 0);
    note(`FWS_REG_STATUS, 32'h17, 32'h12);
    run(`FWS_OP_READ, 22'h00000f, 0);
    note(`FWS_REG_RDATA, 32'hffff, {16'h0, d});
    $display("test good program done");
    run(`FWS_OP_WRITE, 22'h000000, d);
    run(`FWS_OP_POLL, 22'h000000, 0);
    note(`FWS_REG_STATUS, 32'h15, 32'h04);
    run(`FWS_OP_READ, 22'h080005, 0);
    note(`FWS_REG_RDATA, 32'hffff, 32'h5555);
    run(`FWS_OP_READ, 22'h000003, 0);
    note(`FWS_REG_RDATA, 32'h20, 32'h20);
    run(`FWS_OP_RESET, 22'h000000, 0);
    note(`FWS_REG_STATUS, 32'h15, 32'h10);
    run(`FWS_OP_READ, 22'h000000, 0);
    note(`FWS_REG_RDATA, 32'hffff, 32'h0000);
    $display("test failed program done");
    for (int i = 7; i <= 8; i++) begin
      run(`FWS_OP_WINDOW, 22'(i), 0);
      note(`FWS_REG_STATUS, 32'h08, {28'h0, i == 8, 3'h0});
    end
    $display("test window read done");
    conclude();
  end
endmodule : fws_host_tb
